//--- common/svir_if.sv
// Link between the responder core and its vector memory.
`timescale 1ns/1ns
interface svir_if;
   import svir_pkg::*;
   logic wr_en;
   logic [IDX_W-1:0] wr_idx;
   logic [BSEL_W-1:0] wr_bsel;
   logic [7:0] wr_data;
   logic [IDX_W-1:0] rd_idx;
   logic [BSEL_W-1:0] rd_bsel;
   logic rd_valid;
   svir_mode_e mode;
   logic [7:0] rd_data;
   modport core (output wr_en, output wr_idx, output wr_bsel,
      output wr_data, output rd_idx, output rd_bsel, output rd_valid,
      output mode, input rd_data);
   modport mem (input wr_en, input wr_idx, input wr_bsel,
      input wr_data, input rd_idx, input rd_bsel, input rd_valid,
      input mode, output rd_data);
endinterface

//--- common/svir_pkg.sv
// Constants and types shared by the supplied vector interrupt responder.
package svir_pkg;
   localparam int NUM_IN = 8;
   localparam int IDX_W = 3;
   localparam int MAX_BYTES = 4;
   localparam int BSEL_W = 2;
   localparam logic [7:0] RST_BASE = 8'hc7;
   localparam int RST_SHIFT = 3;
   localparam logic [7:0] SPUR_VEC = 8'hff;
   localparam logic [NUM_IN-1:0] REQ_RST = 8'h00;
   localparam logic [2:0] SYNC_RST = 3'h0;
   localparam logic [2:0] ACK_SYNC_RST = 3'h7;
   localparam logic [IDX_W-1:0] IDX_RST = 3'h0;
   localparam logic [BSEL_W-1:0] BSEL_RST = 2'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      SVIR_MODE_RESTART = 2'b00,
      SVIR_MODE_TABLE = 2'b01,
      SVIR_MODE_INSTR = 2'b10
   } svir_mode_e;

   typedef enum logic [1:0] {
      SVIR_ST_IDLE = 2'b00,
      SVIR_ST_DRIVE = 2'b01,
      SVIR_ST_GAP = 2'b10
   } svir_st_e;
endpackage

//--- core/svir_top.sv
// Eight input prioritising interrupt responder with supplied vectors.
// Behaviour
// - On acknowledge, supply the identifying vector code over the data bus.
// - Acknowledge strobe reads vector memory; drive data while strobe low.
// - Instruction mode can supply any complete instruction up to four bytes.
// - Restart mode returns a single byte call selecting one of eight entries.
// - Restart targets are hex 0000 to 0038 in steps of eight.
// - Each request edge is latched once held for two clock samples; no longer pulse is needed.
// - The latched, unmasked inputs are OR-ed into one active low request.
// - Inputs can be masked, prioritised, and near-simultaneous edges resolved.
// - The vector of the highest priority active request is supplied.
`timescale 1ns/1ns
module svir_top
   import svir_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [NUM_IN-1:0] irq_in,
   input wire logic [NUM_IN-1:0] irq_mask,
   input wire logic [IDX_W-1:0] prio_top,
   input wire logic [1:0] vec_mode,
   input wire logic [BSEL_W-1:0] instr_last,
   input wire logic intak_n,
   input wire logic vec_wr_en,
   input wire logic [IDX_W-1:0] vec_wr_idx,
   input wire logic [BSEL_W-1:0] vec_wr_bsel,
   input wire logic [7:0] vec_wr_data,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_n,
   input wire logic intrq_in,
   output logic intrq_out,
   output logic intrq_oe_n,
   output logic [NUM_IN-1:0] pending
);
   // ***************
   // State
   // ***************
   typedef struct packed {
      logic [2:0][NUM_IN-1:0] irq_sync;
      logic [NUM_IN-1:0] irq_stable;
      logic [NUM_IN-1:0] pend;
      logic [2:0] ack_sync;
      logic ack_stable_n;
      svir_st_e st;
      logic win_valid;
      logic [IDX_W-1:0] win_idx;
      logic [BSEL_W-1:0] bsel;
      logic [7:0] data;
      logic oe_n;
   } svir_top_s;

   svir_top_s q_r;
   svir_top_s q_nxt;
   svir_if vif ();

   // ***************
   // Priority search
   // ***************
   // Returns valid and index of the first unmasked pending input, scanning
   // downward from the top-priority position with wrap-around.
   function automatic logic [IDX_W:0] win_find(
      input logic [NUM_IN-1:0] act,
      input logic [IDX_W-1:0] top
   );
      logic [IDX_W:0] res;
      logic [IDX_W-1:0] idx;
      res = '0;
      idx = top;
      for (int i = 0; i < NUM_IN; i++) begin
         idx = top - IDX_W'(i);
         if (act[idx] && !res[IDX_W]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   logic [NUM_IN-1:0] act;
   logic [NUM_IN-1:0] rise;
   logic [NUM_IN-1:0] clr;
   logic [IDX_W:0] pick;
   logic ack_fall;
   logic ack_rise;
   logic done;

   // ***************
   // Vector path
   // ***************
   svir_vec svir_vec_inst (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .vif(vif.mem)
   );

   assign vif.wr_en = vec_wr_en;
   assign vif.wr_idx = vec_wr_idx;
   assign vif.wr_bsel = vec_wr_bsel;
   assign vif.wr_data = vec_wr_data;
   assign vif.mode = svir_mode_e'(vec_mode);
   assign act = q_r.pend & ~irq_mask;

   // The winner is chosen once at the strobe's leading edge and frozen for
   // the whole transfer, so a late request cannot corrupt a multibyte code.
   assign pick = win_find(act, prio_top);
   assign vif.rd_valid = (q_r.st == SVIR_ST_IDLE) ? pick[IDX_W]
      : q_r.win_valid;
   assign vif.rd_idx = (q_r.st == SVIR_ST_IDLE) ? pick[IDX_W-1:0]
      : q_r.win_idx;
   assign vif.rd_bsel = q_r.bsel;

   // ***************
   // Next state
   // ***************
   always_comb begin
      q_nxt = q_r;
      clr = '0;
      done = 1'b0;
      q_nxt.irq_sync = {q_r.irq_sync[1:0], irq_in};
      for (int i = 0; i < NUM_IN; i++) begin
         if (q_r.irq_sync[1][i] == q_r.irq_sync[2][i]) begin
            q_nxt.irq_stable[i] = q_r.irq_sync[2][i];
         end
      end
      rise = q_nxt.irq_stable & ~q_r.irq_stable;
      q_nxt.ack_sync = {q_r.ack_sync[1:0], intak_n};
      if (q_r.ack_sync[1] == q_r.ack_sync[2]) begin
         q_nxt.ack_stable_n = q_r.ack_sync[2];
      end
      ack_fall = q_r.ack_stable_n && !q_nxt.ack_stable_n;
      ack_rise = !q_r.ack_stable_n && q_nxt.ack_stable_n;
      unique case (q_r.st)
         SVIR_ST_IDLE: begin
            if (ack_fall) begin
               q_nxt.st = SVIR_ST_DRIVE;
               q_nxt.win_valid = pick[IDX_W];
               q_nxt.win_idx = pick[IDX_W-1:0];
               q_nxt.data = vif.rd_data;
               q_nxt.oe_n = 1'b0;
            end
         end
         SVIR_ST_DRIVE: begin
            if (ack_rise) begin
               q_nxt.oe_n = 1'b1;
               if (vec_mode != SVIR_MODE_INSTR || q_r.bsel == instr_last) begin
                  done = 1'b1;
               end else begin
                  q_nxt.bsel = q_r.bsel + 1'b1;
                  q_nxt.st = SVIR_ST_GAP;
               end
            end
         end
         SVIR_ST_GAP: begin
            if (ack_fall) begin
               q_nxt.st = SVIR_ST_DRIVE;
               q_nxt.data = vif.rd_data;
               q_nxt.oe_n = 1'b0;
            end
         end
         default: begin
            q_nxt.st = SVIR_ST_IDLE;
         end
      endcase
      if (done) begin
         q_nxt.st = SVIR_ST_IDLE;
         q_nxt.bsel = BSEL_RST;
         q_nxt.win_valid = 1'b0;
         if (q_r.win_valid) begin
            clr[q_r.win_idx] = 1'b1;
         end
      end
      // A new edge on the input being cleared wins, so it is not lost.
      q_nxt.pend = (q_r.pend & ~clr) | rise;
   end

   // ***************
   // Registers and outputs
   // ***************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q_r.irq_sync <= {3{REQ_RST}};
         q_r.irq_stable <= REQ_RST;
         q_r.pend <= REQ_RST;
         q_r.ack_sync <= ACK_SYNC_RST;
         q_r.ack_stable_n <= 1'b1;
         q_r.st <= SVIR_ST_IDLE;
         q_r.win_valid <= 1'b0;
         q_r.win_idx <= IDX_RST;
         q_r.bsel <= BSEL_RST;
         q_r.data <= BYTE_RST;
         q_r.oe_n <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign data_out = q_r.data;
   assign data_oe_n = q_r.oe_n;
   // Open-drain request: pull low only, other cards share the wire.
   assign intrq_out = 1'b0;
   assign intrq_oe_n = ~(|act);
   assign pending = q_r.pend;
endmodule // svir_top

//--- core/svir_vec.sv
// Vector memory and vector code generation.
`timescale 1ns/1ns
module svir_vec
   import svir_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   svir_if.mem vif
);
   typedef struct packed {
      logic [NUM_IN*MAX_BYTES-1:0][7:0] mem;
   } svir_vec_s;

   svir_vec_s q_r;
   svir_vec_s q_nxt;
   logic [7:0] code;

   // The table holds four bytes per source so any complete instruction fits.
   always_comb begin
      q_nxt = q_r;
      if (vif.wr_en) begin
         q_nxt.mem[{vif.wr_idx, vif.wr_bsel}] = vif.wr_data;
      end
   end

   always_comb begin
      code = SPUR_VEC;
      if (vif.rd_valid) begin
         unique case (vif.mode)
            SVIR_MODE_RESTART: begin
               // The index is widened before the shift so no bits are lost.
               code = RST_BASE
                  | (8'(vif.rd_idx) << RST_SHIFT);
            end
            SVIR_MODE_TABLE: begin
               code = q_r.mem[{vif.rd_idx, BSEL_RST}];
            end
            SVIR_MODE_INSTR: begin
               code = q_r.mem[{vif.rd_idx, vif.rd_bsel}];
            end
            default: begin
               code = SPUR_VEC;
            end
         endcase
      end
   end

   assign vif.rd_data = code;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule // svir_vec

//--- dv/supplied_vector_interrupt_responder_tb_top.sv
// Self-checking bench for the supplied vector interrupt responder.
`timescale 1ns/1ns
module supplied_vector_interrupt_responder_tb_top;
   import svir_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] irq_in = 8'h00, irq_mask = 8'h00, vec_wr_data = 8'h00;
   logic [2:0] prio_top = 3'h7, vec_wr_idx = 3'h0;
   logic [1:0] vec_mode = 2'h0, instr_last = 2'h0, vec_wr_bsel = 2'h0;
   logic vec_wr_en = 1'b0;
   logic intak_n, data_oe_n, intrq_in, intrq_out, intrq_oe_n;
   logic [7:0] data_in, data_out, pending;
   int errors = 0, checked = 0, i;
   assign intrq_in = intrq_oe_n ? 1'b1 : intrq_out;
   always #4 clk_sys = ~clk_sys;
   svir_top svir_top_inst (.clk_sys, .nrst, .irq_in, .irq_mask, .prio_top,
      .vec_mode, .instr_last, .intak_n, .vec_wr_en, .vec_wr_idx,
      .vec_wr_bsel, .vec_wr_data, .data_in, .data_out, .data_oe_n,
      .intrq_in, .intrq_out, .intrq_oe_n, .pending);
   svir_host svir_host_inst (.clk_sys, .data_out, .data_oe_n, .intak_n,
      .data_in);
   // ***************
   // Shared tasks
   // ***************
   task close_out;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task check(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task raise(logic [7:0] m);
      @(posedge clk_sys) irq_in <= m;
      repeat (4) @(posedge clk_sys);
      irq_in <= 8'h00;
      repeat (6) @(posedge clk_sys);
   endtask
   task ack_chk(string name, logic [7:0] exp, bit alt = 1'b0);
      logic [7:0] d;
      bit ok;
      svir_host_inst.ack(alt, d, ok);
      if (!ok) begin
         errors++;
         close_out();
      end else begin
         check(name, d, exp);
      end
   endtask
   task wr(logic [2:0] idx, logic [1:0] b, logic [7:0] d);
      @(posedge clk_sys);
      {vec_wr_en, vec_wr_idx, vec_wr_bsel, vec_wr_data} <= {1'b1, idx, b, d};
      @(posedge clk_sys) vec_wr_en <= 1'b0;
   endtask
   // ***************
   // Scenarios
   // ***************
   task t_restart;
      for (i = 0; i < 8; i++) begin
         raise(8'h01 << i);
         check("pend", pending, 8'h01 << i);
         ack_chk("rst", 8'hc7 | 8'(i << 3));
      end
      check("clr", pending, 8'h00);
      $display("done restart");
   endtask
   task t_prio;
      prio_top <= 3'h2;
      raise(8'h42);
      ack_chk("hi", 8'hcf);
      ack_chk("lo", 8'hf7, 1'b1);
      $display("done prio");
   endtask
   task t_mask;
      irq_mask <= 8'h10;
      raise(8'h10);
      check("mpend", pending, 8'h10);
      check("mreq", {7'h0, intrq_oe_n}, 8'h01);
      @(posedge clk_sys) irq_mask <= 8'h00;
      repeat (2) @(posedge clk_sys);
      check("ureq", {7'h0, intrq_oe_n}, 8'h00);
      ack_chk("mvec", 8'he7);
      $display("done mask");
   endtask
   task t_table_instr;
      wr(3'h5, 2'h0, 8'h3a);
      for (i = 0; i < 4; i++) wr(3'h2, 2'(i), 8'ha0 + 8'(i));
      vec_mode <= 2'h1;
      raise(8'h20);
      ack_chk("tbl", 8'h3a);
      vec_mode <= 2'h2;
      instr_last <= 2'h3;
      raise(8'h04);
      for (i = 0; i < 4; i++) begin
         check("ipend", pending, 8'h04);
         ack_chk("ins", 8'ha0 + 8'(i));
      end
      repeat (2) @(posedge clk_sys);
      check("iclr", pending, 8'h00);
      // With instr_last at 0, a single strobe returns the opcode byte and clears the request.
      instr_last <= 2'h0;
      raise(8'h04);
      ack_chk("op", 8'ha0);
      check("oclr", pending, 8'h00);
      $display("done table instr");
   endtask
   task t_reset;
      raise(8'h08);
      check("rpend", pending, 8'h08);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("rclr", pending, 8'h00);
      check("rreq", {7'h0, intrq_oe_n}, 8'h01);
      nrst <= 1'b1;
      vec_mode <= 2'h1;
      raise(8'h20);
      ack_chk("rtbl", 8'h00);
      $display("done reset");
   endtask
   task t_spur;
      vec_mode <= 2'h0;
      ack_chk("spur", SPUR_VEC);
      check("spend", pending, 8'h00);
      $display("done spurious");
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      t_restart();
      t_prio();
      t_mask();
      t_table_instr();
      t_reset();
      t_spur();
      close_out();
   end
endmodule // supplied_vector_interrupt_responder_tb_top

//--- dv/svir_host.sv
// Host processor model that acknowledges and reads the data bus.
`timescale 1ns/1ns
module svir_host (
   input wire logic clk_sys,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   output logic intak_n,
   output logic [7:0] data_in
);
   logic opcode_fetch_cycle_n = 1'b1;
   logic io_request_n = 1'b1;
   logic bus_available = 1'b0;
   logic bus_status = 1'b0;
   logic [7:0] last_r = 8'h00;
   // Either processor style may form the strobe; both pairs idle inactive.
   assign intak_n = (opcode_fetch_cycle_n | io_request_n)
      & ~(bus_available & bus_status);
   // Main memory stays silent; a released bus shows no stale vector.
   assign data_in = data_oe_n ? ~last_r : data_out;
   always @(posedge clk_sys) if (!data_oe_n) last_r <= data_out;
   task automatic ack(input bit alt, output logic [7:0] d, output bit ok);
      int n;
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk_sys);
      if (alt) begin
         bus_available <= 1'b1;
         bus_status <= 1'b1;
      end else begin
         opcode_fetch_cycle_n <= 1'b0;
         io_request_n <= 1'b0;
      end
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge clk_sys);
         ok = (data_oe_n === 1'b0);
      end
      d = data_in;
      opcode_fetch_cycle_n <= 1'b1;
      io_request_n <= 1'b1;
      bus_available <= 1'b0;
      bus_status <= 1'b0;
      for (n = 0; n < 20 && data_oe_n !== 1'b1; n++) @(posedge clk_sys);
      if (data_oe_n !== 1'b1) ok = 1'b0;
   endtask
endmodule // svir_host

//--- dv/svir_sva.sv
// Port assertions for the supplied vector interrupt responder.
`timescale 1ns/1ns
module svir_sva
   import svir_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [NUM_IN-1:0] irq_in,
   input wire logic [NUM_IN-1:0] irq_mask,
   input wire logic [1:0] vec_mode,
   input wire logic intak_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic intrq_out,
   input wire logic intrq_oe_n,
   input wire logic [NUM_IN-1:0] pending
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // The strobe is filtered, so each window allows for the sync delay.
   sequence s_ack_held;
      (!intak_n)[*5];
   endsequence
   sequence s_idle_held;
      intak_n[*6];
   endsequence
   sequence s_req_edge;
      $rose(irq_in[0]) ##1 irq_in[0][*3];
   endsequence
   drive_on_ack_a: assert property (s_ack_held |-> !data_oe_n)
      else $error("bus not driven during acknowledge");
   bus_release_a: assert property (s_idle_held |-> data_oe_n)
      else $error("bus still driven after acknowledge");
   req_latch_a: assert property (s_req_edge |-> ##[0:4] pending[0])
      else $error("request edge not latched");
   pend_kept_a: assert property (s_idle_held ##1 intak_n |->
      (pending & $past(pending)) == $past(pending))
      else $error("pending cleared without acknowledge");
   intrq_level_a: assert property ($stable(irq_mask) |->
      intrq_oe_n == !(|(pending & ~irq_mask)))
      else $error("request line does not follow pending");
   intrq_zero_a: assert property (intrq_out == 1'b0)
      else $error("request line driven high");
   restart_fmt_a: assert property (
      vec_mode == 2'b00 && !data_oe_n |->
      data_out[7:6] == 2'b11 && data_out[2:0] == 3'h7)
      else $error("restart code malformed");
   data_hold_a: assert property (
      !data_oe_n ##1 !data_oe_n |-> $stable(data_out))
      else $error("vector changed while driven");
endmodule // svir_sva
bind svir_top svir_sva svir_sva_inst (.clk_sys, .nrst, .irq_in, .irq_mask,
   .vec_mode, .intak_n, .data_out, .data_oe_n, .intrq_out, .intrq_oe_n,
   .pending);
